// *** pkg/arb_pkg.sv ***
// Purpose : Shared constants and carriers for the redundant controller arbiter
// Assumes : Two control card slots, one 250 MHz clock, synchronous reset
// Notes   : Slot 0 wins a tie when neither card holds the grant

package arb_pkg;

    // ----------------------------------------------------------------
    // Sizes and fixed choices
    // ----------------------------------------------------------------
    localparam int unsigned SLOTS     = 2;      // Control card slots
    localparam int unsigned PRIO_SLOT = 0;      // Slot that wins a tie
    localparam logic        ACTIVE_RST = 1'b0;  // Active indication at reset
    localparam logic        IRQ_RST    = 1'b0;  // Interrupt pulse at reset
    localparam logic        PIN_RST    = 1'b0;  // Synchroniser stages at reset

    // ----------------------------------------------------------------
    // Arbiter states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ARB_IDLE   = 3'b001,                    // Nobody holds the grant
        ARB_GRANT0 = 3'b010,                    // Slot 0 is active
        ARB_GRANT1 = 3'b100                     // Slot 1 is active
    } arb_state_t;

    // ----------------------------------------------------------------
    // Per-card indication bundle
    // ----------------------------------------------------------------
    typedef struct packed {
        logic active;                           // This card is the primary
        logic irq;                              // One-cycle interrupt pulse
        logic peer_ready;                       // Readiness of the other card
        logic peer_active;                      // Active state of the other card
    } card_stat_t;

endpackage

// *** logic/pin_sync.sv ***
// Purpose : Bring one asynchronous pin level into the clock domain
// Assumes : Pin changes slowly compared to the clock
// Notes   : A change is accepted once stages two and three agree

`timescale 1ns/1ps

module pin_sync
    import arb_pkg::*;
(
    input  wire logic clock,      // System clock
    input  wire logic rst,        // Synchronous reset, active high
    input  wire logic pin_in,     // Raw pin level
    output logic      level_out   // Filtered, synchronised level
);

    // ----------------------------------------------------------------
    // Stage registers
    // ----------------------------------------------------------------
    logic s1_q, s1_d;             // First stage, read only by second
    logic s2_q, s2_d;             // Second stage
    logic s3_q, s3_d;             // Third stage
    logic lvl_q, lvl_d;           // Accepted level

    // Next values of the chain
    always_comb
    begin
        s1_d  = pin_in;
        s2_d  = s1_q;
        s3_d  = s2_q;
        lvl_d = lvl_q;
        // Accept only when two later stages agree
        if (s2_q == s3_q)
        begin
            lvl_d = s3_q;
        end
    end

    // Register the chain
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s1_q  <= PIN_RST;
            s2_q  <= PIN_RST;
            s3_q  <= PIN_RST;
            lvl_q <= PIN_RST;
        end
        else
        begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;

endmodule

// *** logic/redundant_controller_arbiter.sv ***
// Purpose : Pick which of two control cards is active, the other standby
// Assumes : Card readiness and presence arrive as asynchronous pin levels
// Notes   : Slot 0 has priority on a tie; grant never moves while holder ready

`timescale 1ns/1ps

module redundant_controller_arbiter
    import arb_pkg::*;
(
    input  wire logic         clock,         // 250 MHz system clock
    input  wire logic         rst,           // Synchronous reset, active high
    input  wire logic [1:0]   card_ready,    // Readiness pin per card
    input  wire logic [1:0]   card_present,  // Card seated and powered, per slot
    output card_stat_t [1:0]  card_status    // Indications back to each card
);

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    logic [1:0] rdy_s;                       // Synchronised readiness
    logic [1:0] pres_s;                      // Synchronised presence
    logic [1:0] ok;                          // Card eligible for the grant

    // One synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi++)
        begin : g_sync
            pin_sync u_rdy
            (
                .clock     (clock),
                .rst       (rst),
                .pin_in    (card_ready[gi]),
                .level_out (rdy_s[gi])
            );
            pin_sync u_pres
            (
                .clock     (clock),
                .rst       (rst),
                .pin_in    (card_present[gi]),
                .level_out (pres_s[gi])
            );
        end
    endgenerate

    // A removed or unpowered card counts as not ready
    assign ok = rdy_s & pres_s;

    // ----------------------------------------------------------------
    // Arbitration state machine
    // ----------------------------------------------------------------
    arb_state_t state_q, state_d;            // Current holder

    // Next holder
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            // No holder: grant only a ready card, slot 0 first
            ARB_IDLE:
            begin
                if (ok[PRIO_SLOT])
                begin
                    state_d = ARB_GRANT0;
                end
                else if (ok[1])
                begin
                    state_d = ARB_GRANT1;
                end
            end
            // Slot 0 holds the grant
            ARB_GRANT0:
            begin
                if (!ok[0])
                begin
                    if (ok[1])
                    begin
                        state_d = ARB_GRANT1;
                    end
                    else
                    begin
                        state_d = ARB_IDLE;
                    end
                end
            end
            // Slot 1 holds the grant
            ARB_GRANT1:
            begin
                if (!ok[1])
                begin
                    if (ok[0])
                    begin
                        state_d = ARB_GRANT0;
                    end
                    else
                    begin
                        state_d = ARB_IDLE;
                    end
                end
            end
            // Illegal code: drop the grant safely
            default:
            begin
                state_d = ARB_IDLE;
            end
        endcase
    end

    // Register the holder
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= ARB_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Indications to the cards
    // ----------------------------------------------------------------
    logic [1:0] act_q, act_d;                // Active per card
    logic       irq_q, irq_d;                // Change pulse, sent to both
    logic [1:0] fwd_q, fwd_d;                // Forwarded readiness

    // Next indications
    always_comb
    begin
        act_d[0] = (state_d == ARB_GRANT0);
        act_d[1] = (state_d == ARB_GRANT1);
        irq_d = (act_d != act_q);
        fwd_d[0] = rdy_s[1];
        fwd_d[1] = rdy_s[0];
    end

    // Register the indications
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            act_q <= {SLOTS{ACTIVE_RST}};
            irq_q <= IRQ_RST;
            fwd_q <= {SLOTS{PIN_RST}};
        end
        else
        begin
            act_q <= act_d;
            irq_q <= irq_d;
            fwd_q <= fwd_d;
        end
    end

    // Pack per-card bundles, peer fields mirror the other slot
    always_comb
    begin
        card_status[0].active      = act_q[0];
        card_status[0].irq         = irq_q;
        card_status[0].peer_ready  = fwd_q[0];
        card_status[0].peer_active = act_q[1];
        card_status[1].active      = act_q[1];
        card_status[1].irq         = irq_q;
        card_status[1].peer_ready  = fwd_q[1];
        card_status[1].peer_active = act_q[0];
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    // Never two active cards
    property p_one_active;
        @(posedge clock) disable iff (rst)
        !(card_status[0].active && card_status[1].active);
    endproperty
    a_one_active: assert property (p_one_active) else $error("Both cards active");

    // Readiness seen by card 0 is card 1's, one cycle late
    property p_forward;
        @(posedge clock) disable iff (rst)
        ##1 (card_status[0].peer_ready == $past(rdy_s[1]))
            && (card_status[1].peer_ready == $past(rdy_s[0]));
    endproperty
    a_forward: assert property (p_forward) else $error("Readiness not forwarded");

    // A card granted slot 1 was eligible when the grant was decided
    property p_only_ready;
        @(posedge clock) disable iff (rst)
        $rose(card_status[1].active) |-> $past(ok[1]);
    endproperty
    a_only_ready: assert property (p_only_ready) else $error("Unready card granted");

    // Slot 0 likewise was eligible when its grant was decided
    property p_only_ready0;
        @(posedge clock) disable iff (rst)
        $rose(card_status[0].active) |-> $past(ok[0]);
    endproperty
    a_only_ready0: assert property (p_only_ready0) else $error("Unready card granted");

    // Any change of active raises the interrupt on both cards
    property p_irq_both;
        @(posedge clock) disable iff (rst)
        $changed(card_status[0].active) || $changed(card_status[1].active)
            |-> card_status[0].irq && card_status[1].irq;
    endproperty
    a_irq_both: assert property (p_irq_both) else $error("Missing interrupt");

    // Holder 0 fails, ready standby takes over next cycle with interrupt
    property p_failover;
        @(posedge clock) disable iff (rst)
        card_status[0].active && !ok[0] && ok[1]
            |=> card_status[1].active && card_status[1].irq && !card_status[0].active;
    endproperty
    a_failover: assert property (p_failover) else $error("No fail over");

    // Tie with no holder goes to slot 0
    property p_tie;
        @(posedge clock) disable iff (rst)
        (state_q == ARB_IDLE) && (ok == 2'h3)
            |=> card_status[0].active && !card_status[1].active;
    endproperty
    a_tie: assert property (p_tie) else $error("Tie not resolved to slot 0");

    // Slot 1 keeps the grant while ready, even with slot 0 ready
    property p_keep1;
        @(posedge clock) disable iff (rst)
        card_status[1].active && ok[1] |=> card_status[1].active;
    endproperty
    a_keep1: assert property (p_keep1) else $error("Grant moved from ready holder");

    // Slot 0 keeps the grant while ready; only the cycle after counts,
    // since readiness may drop again at any later cycle
    property p_keep0;
        @(posedge clock) disable iff (rst)
        card_status[0].active && ok[0]
            |=> card_status[0].active && !card_status[1].active;
    endproperty
    a_keep0: assert property (p_keep0) else $error("Grant dropped by ready holder");

endmodule

// *** sim/card_model.sv ***
// Purpose : Behavioural control card that boots, judges itself and follows the grant
// Assumes : Boot and self-test take BOOT_CYC cycles after reset
// Notes   : fit stands for passed self-tests, peers reached and reset lines idle

`timescale 1ns/1ps

module card_model
    import arb_pkg::*;
#(
    parameter int BOOT_CYC = 8               // Boot and self-test length
)
(
    input  wire logic       clock,           // System clock
    input  wire logic       rst,             // Synchronous reset, active high
    input  wire logic       fit,             // Card judges itself fit
    input  wire card_stat_t stat,            // Indications from the arbiter
    output logic            ready,           // Readiness pin
    output logic            primary          // Software runs primary code
);
    int boot_cnt;                            // Cycles spent booting

    // ----------------------------------------------------------------
    // Boot and readiness
    // ----------------------------------------------------------------
    // boot before ready
    always @(posedge clock)
    begin
        if (rst)
        begin
            boot_cnt <= 0;
            ready    <= #1 1'b0;
        end
        else
        begin
            // Still booting: readiness stays low
            if (boot_cnt < BOOT_CYC)
                boot_cnt <= boot_cnt + 1;
            ready <= #1 fit && (boot_cnt >= BOOT_CYC);
        end
    end

    // ----------------------------------------------------------------
    // Software mode
    // ----------------------------------------------------------------
    // branch on interrupt
    always @(posedge clock)
    begin
        if (rst)
            primary <= 1'b0;
        else if (stat.irq === 1'b1)
            primary <= stat.active;
    end
endmodule

// *** sim/redundant_controller_arbiter_tb.sv ***
// Purpose : Self-checking bench for the two-card arbiter
// Assumes : Pin to output latency well under ten cycles
// Notes   : Interrupts counted on card 0 only; at most one holder checked every cycle

`timescale 1ns/1ps

module redundant_controller_arbiter_tb
    import arb_pkg::*;
;
    logic              clock = 1'b0;         // System clock
    logic              rst;                  // Reset
    logic [1:0]        fit;                  // Fitness per card
    logic [1:0]        present;              // Presence per slot
    wire logic [1:0]   card_ready;           // Readiness from the cards
    wire logic [1:0]   primary;              // Software mode per card
    card_stat_t [1:0]  card_status;          // Arbiter indications
    wire logic [1:0]   act;                  // Active vector
    int                irq_cnt0;             // Interrupts seen by card 0
    int                num_errors = 0;       // Mismatches
    int                compares = 0;         // Comparisons

    assign act = {card_status[1].active, card_status[0].active};

    // Clock, 4 ns period
    always #2 clock = ~clock;

    redundant_controller_arbiter u_dut (.clock(clock), .rst(rst), .card_ready(card_ready),
        .card_present(present), .card_status(card_status));
    card_model u_card0 (.clock(clock), .rst(rst), .fit(fit[0]), .stat(card_status[0]),
        .ready(card_ready[0]), .primary(primary[0]));
    card_model u_card1 (.clock(clock), .rst(rst), .fit(fit[1]), .stat(card_status[1]),
        .ready(card_ready[1]), .primary(primary[1]));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Drive pins, let them settle, then judge grant, peer view and interrupts
    task automatic step(input logic [1:0] f, input logic [1:0] p, input logic [1:0] ea, input int ei);
        int i0;
        i0 = irq_cnt0;
        @(posedge clock);
        #1;
        fit = f;
        present = p;
        repeat (10) @(posedge clock);
        #1;
        chk({6'h00, act}, {6'h00, ea});
        chk({6'h00, card_status[0].peer_active, card_status[1].peer_active}, {6'h00, ea});
        chk(8'(irq_cnt0 - i0), 8'(ei));
    endtask

    // Every cycle: never two holders, interrupts on both cards together
    always @(posedge clock)
    begin
        if (rst)
            irq_cnt0 <= 0;
        else
        begin
            irq_cnt0 <= irq_cnt0 + (card_status[0].irq === 1'b1);
            chk({6'h00, act === 2'b11, card_status[0].irq !== card_status[1].irq}, 8'h00);
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_tie();
        step(2'b11, 2'b11, 2'b01, 1);
        chk({6'h00, primary}, 8'h01);
        $display("test tie done");
    endtask

    task automatic t_keep();
        step(2'b01, 2'b11, 2'b01, 0);
        chk({6'h00, card_status[0].peer_ready, card_status[1].peer_ready}, 8'h01);
        step(2'b11, 2'b11, 2'b01, 0);
        chk({6'h00, card_status[0].peer_ready, card_status[1].peer_ready}, 8'h03);
        $display("test keep done");
    endtask

    task automatic t_drop();
        step(2'b10, 2'b11, 2'b10, 1);
        chk({6'h00, primary}, 8'h02);
        $display("test drop done");
    endtask

    task automatic t_remove();
        step(2'b11, 2'b11, 2'b10, 0);
        step(2'b11, 2'b01, 2'b01, 1);
        $display("test remove done");
    endtask

    task automatic t_none();
        step(2'b11, 2'b00, 2'b00, 1);
        step(2'b11, 2'b11, 2'b01, 1);
        $display("test none done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        fit = 2'b00;
        present = 2'b11;
        repeat (3) @(posedge clock);
        #1;
        rst = 1'b0;
        repeat (12) @(posedge clock);
        #1;
        chk({6'h00, act}, 8'h00);
        t_tie();
        t_keep();
        t_drop();
        t_remove();
        t_none();
        report_and_stop();
    end

    // Cut a hang short well past the expected run length
    initial
    begin
        #10000;
        num_errors++;
        report_and_stop();
    end
endmodule
